// ---- rtl/ppg_top.sv ----
/*
 * pseudo-random and programmable-data pattern generator with ahb-lite
 * register slave, burst gate, pattern marker and error addition.
 * assumes one clock; clock_en low freezes all state; one bit per enabled
 * clock while running.
 *
 */
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`default_nettype none

module ppg_top
    import ppg_pkg::*;
#(
    parameter logic [31:0] BURST_EN_BITS  = DEF_BEN,
    parameter logic [31:0] BURST_CYC_BITS = DEF_BCYC
)(
    input  wire logic        clock,
    input  wire logic        clock_en,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             data_out,
    output logic             marker_out,
    output logic             burst_gate
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  len_sel;
        logic        pol_neg;
        logic [1:0]  ratio;
        logic        mode_data;
        logic [1:0]  gang;
        logic        err_add;
        logic        burst_on;
        logic        run;
        logic [31:0] mark_pos;
        logic [31:0] data_pat;
        logic [5:0]  data_len;
        logic [31:0] burst_en;
        logic [31:0] burst_cyc;
        logic [15:0] mix_row;
        logic [15:0] mix_data;
        logic [15:0] mix_cnt;
        logic [31:0] pos;
        logic [31:0] bcnt;
        logic [9:0]  ecnt;
        logic        ph_act;
        logic        ph_wr;
        logic [7:0]  ph_addr;
        logic [31:0] hrdata;
        logic        data_out;
        logic        marker;
        logic        gate;
        logic [30:0] snap;
        logic        snap_ok;
        logic [5:0]  ones;
    } ppg_state_t;

    function automatic ppg_state_t with_defaults(input ppg_state_t v);
        ppg_state_t r;
        r           = v;
        r.len_sel   = DEF_LEN_SEL;
        r.pol_neg   = 1'b0;
        r.ratio     = RATIO_HALF;
        r.mode_data = 1'b0;
        r.gang      = 2'h0;
        r.err_add   = 1'b0;
        r.burst_on  = 1'b0;
        r.mark_pos  = DEF_MARK;
        r.data_pat  = DEF_DPAT;
        r.data_len  = DEF_DLEN;
        r.burst_en  = BURST_EN_BITS;
        r.burst_cyc = BURST_CYC_BITS;
        r.mix_row   = DEF_MROW;
        r.mix_data  = DEF_MDAT;
        r.mix_cnt   = DEF_MCNT;
        return r;
    endfunction

    localparam ppg_state_t RST_VAL = with_defaults('0);

    ppg_state_t  s_reg;
    ppg_state_t  s_next;
    logic [30:0] lfsr_state;
    logic [4:0]  n_len;
    logic        top_bit;
    logic        nxt_bit;
    logic        prbs_bit;
    logic        seq_raw;
    logic        flip;
    logic        wr_ctrl;
    logic [31:0] dlen_eff;
    logic [31:0] ben_eff;
    logic [31:0] bcyc_eff;
    logic [31:0] period;
    logic [31:0] rd;

    ppg_lfsr u_lfsr (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .step     (s_reg.run),
        .reload   (wr_ctrl),
        .len_sel  (s_reg.len_sel),
        .state    (lfsr_state)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_next   = s_reg;
        wr_ctrl  = 1'b0;
        rd       = 32'h0;
        n_len    = ppg_len(s_reg.len_sel);
        top_bit  = lfsr_state[n_len - 5'd1];
        nxt_bit  = lfsr_state[n_len - 5'd2];
        case (s_reg.ratio)
            RATIO_QUARTER: prbs_bit = top_bit & nxt_bit;
            RATIO_3Q:      prbs_bit = top_bit | nxt_bit;
            default:       prbs_bit = top_bit;
        endcase
        dlen_eff = ppg_scale({26'h0, s_reg.data_len}, s_reg.gang);
        ben_eff  = ppg_scale(s_reg.burst_en, s_reg.gang);
        bcyc_eff = ppg_scale(s_reg.burst_cyc, s_reg.gang);
        period   = s_reg.mode_data ? dlen_eff : {1'b0, ppg_mask(s_reg.len_sel)};
        seq_raw  = s_reg.mode_data ? s_reg.data_pat[s_reg.pos[4:0]] : prbs_bit;
        flip     = s_reg.run && s_reg.err_add && (s_reg.ecnt == 10'h0);

        if (s_reg.run) begin
            s_next.pos      = (s_reg.pos >= period - 32'h1) ? 32'h0 : s_reg.pos + 32'h1;
            s_next.bcnt     = (s_reg.bcnt >= bcyc_eff - 32'h1) ? 32'h0 : s_reg.bcnt + 32'h1;
            s_next.ecnt     = (s_reg.ecnt >= ERR_GAP - 10'h1) ? 10'h0 : s_reg.ecnt + 10'h1;
            s_next.data_out = (seq_raw ^ flip) ^ ~s_reg.pol_neg;
        end
        s_next.marker = s_reg.run && (s_reg.pos == s_reg.mark_pos - 32'h1);
        s_next.gate   = !s_reg.burst_on || (s_reg.bcnt < ben_eff);

        // helpers for the period and run-length checks
        if (s_reg.run && !s_reg.mode_data && s_reg.pos == 32'h0) begin
            s_next.snap    = lfsr_state & ppg_mask(s_reg.len_sel);
            s_next.snap_ok = 1'b1;
        end
        if (s_reg.run && !s_reg.mode_data && s_reg.ratio == RATIO_HALF) begin
            s_next.ones = seq_raw ? s_reg.ones + 6'h1 : 6'h0;
        end else if (s_reg.run) begin
            s_next.ones = 6'h0;
        end

        // ------------------------------------------------------------
        // register writes in the data phase
        // ------------------------------------------------------------
        if (s_reg.ph_act && s_reg.ph_wr) begin
            case (s_reg.ph_addr)
                OFS_CTRL: begin
                    wr_ctrl = 1'b1;
                    if (hwdata[CTL_INIT]) begin
                        s_next = with_defaults(s_next);
                    end else begin
                        s_next.len_sel   = hwdata[CTL_LEN_LSB +: 3];
                        s_next.pol_neg   = hwdata[CTL_POL];
                        s_next.ratio     = hwdata[CTL_RATIO_LSB +: 2];
                        s_next.mode_data = hwdata[CTL_MODE];
                        s_next.gang      = hwdata[CTL_GANG_LSB +: 2];
                        s_next.err_add   = hwdata[CTL_ERR];
                        s_next.burst_on  = hwdata[CTL_BURST];
                        s_next.run       = hwdata[CTL_RUN];
                    end
                    // pattern restarts so position and shift register stay aligned
                    s_next.pos     = 32'h0;
                    s_next.bcnt    = 32'h0;
                    s_next.ecnt    = 10'h0;
                    s_next.snap_ok = 1'b0;
                    s_next.ones    = 6'h0;
                end
                OFS_MARK: s_next.mark_pos  = hwdata;
                OFS_DPAT: s_next.data_pat  = hwdata;
                OFS_DLEN: s_next.data_len  = hwdata[5:0];
                OFS_BEN:  s_next.burst_en  = hwdata;
                OFS_BCYC: s_next.burst_cyc = hwdata;
                OFS_MROW: s_next.mix_row   = hwdata[15:0];
                OFS_MDAT: s_next.mix_data  = hwdata[15:0];
                OFS_MCNT: s_next.mix_cnt   = hwdata[15:0];
                default:  s_next.run       = s_next.run;
            endcase
        end

        // ------------------------------------------------------------
        // address phase; read data comes from the post-write values, except status and shift register, read as they stand now
        // ------------------------------------------------------------
        s_next.ph_act  = hsel && hready && htrans[1];
        s_next.ph_wr   = hwrite;
        s_next.ph_addr = haddr[7:0];
        case (haddr[7:0])
            OFS_CTRL: rd = {20'h0, s_next.run, s_next.burst_on, s_next.err_add, s_next.gang,
                            s_next.mode_data, s_next.ratio, s_next.pol_neg, s_next.len_sel};
            OFS_STAT: rd = s_reg.pos;
            OFS_LFSR: rd = {1'b0, lfsr_state};
            OFS_MARK: rd = s_next.mark_pos;
            OFS_DPAT: rd = s_next.data_pat;
            OFS_DLEN: rd = ppg_scale({26'h0, s_next.data_len}, s_next.gang);
            OFS_BEN:  rd = ppg_scale(s_next.burst_en, s_next.gang);
            OFS_BCYC: rd = ppg_scale(s_next.burst_cyc, s_next.gang);
            OFS_MROW: rd = ppg_scale({16'h0, s_next.mix_row}, s_next.gang);
            OFS_MDAT: rd = ppg_scale({16'h0, s_next.mix_data}, s_next.gang);
            OFS_MCNT: rd = {16'h0, s_next.mix_cnt};
            default:  rd = 32'h0;
        endcase
        if (s_next.ph_act && !hwrite) begin
            s_next.hrdata = rd;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= RST_VAL;
        end else if (clock_en) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero-wait slave; clock_en low stretches nothing, so the master must
    // not run the bus while the block is frozen
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = s_reg.hrdata;
    assign data_out   = s_reg.data_out;
    assign marker_out = s_reg.marker;
    assign burst_gate = s_reg.gate;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_init_write;
        clock_en && s_reg.ph_act && s_reg.ph_wr && s_reg.ph_addr == OFS_CTRL && hwdata[CTL_INIT];
    endsequence

    sequence s_prbs_step;
        clock_en && s_reg.run && !s_reg.mode_data && !wr_ctrl;
    endsequence

    AST_PERIOD: assert property (
        (s_prbs_step and (s_reg.pos == 32'h0 && s_reg.snap_ok))
        |-> ((lfsr_state & ppg_mask(s_reg.len_sel)) == s_reg.snap)
    ) else $error("prbs state differs one period later");

    AST_ONES_RUN: assert property (
        (s_reg.ones <= {1'b0, ppg_len(s_reg.len_sel)})
    ) else $error("run of ones longer than the degree");

    AST_POLARITY: assert property (
        (clock_en && s_reg.run && !s_reg.pol_neg && !flip && !wr_ctrl) |=> (data_out == !$past(seq_raw))
    ) else $error("positive logic output level wrong");

    AST_QUARTER: assert property (
        (s_prbs_step and (s_reg.ratio == RATIO_QUARTER && s_reg.pol_neg && !flip))
        |=> (data_out == $past(lfsr_state[n_len - 5'd1] & lfsr_state[n_len - 5'd2]))
    ) else $error("quarter mark ratio not the and of two stages");

    AST_INIT: assert property (
        s_init_write |=> (s_reg.len_sel == DEF_LEN_SEL && !s_reg.pol_neg
                          && s_reg.ratio == RATIO_HALF && !s_reg.err_add && s_reg.gang == 2'h0)
    ) else $error("initialisation did not restore defaults");

    AST_DATA_WRAP: assert property (
        (clock_en && s_reg.run && s_reg.mode_data && !wr_ctrl && s_reg.pos == dlen_eff - 32'h1)
        |=> (s_reg.pos == 32'h0)
    ) else $error("data pattern did not wrap at scaled length");

    AST_MIXED: assert property (
        s_init_write |=> (s_reg.mix_row == DEF_MROW && s_reg.mix_data == DEF_MDAT
                          && s_reg.mix_cnt == DEF_MCNT)
    ) else $error("mixed data defaults not restored");

    AST_BURST: assert property (
        (clock_en && s_reg.burst_on && s_reg.bcnt >= ben_eff) |=> !burst_gate
    ) else $error("burst gate open outside enable period");

    AST_MARKER: assert property (
        (clock_en && s_reg.run && s_reg.pos == s_reg.mark_pos - 32'h1) |=> marker_out
    ) else $error("marker missing at selected position");

    AST_NO_ERROR: assert property (
        (clock_en && s_reg.run && !s_reg.err_add && s_reg.pol_neg && !wr_ctrl)
        |=> (data_out == $past(seq_raw))
    ) else $error("bit altered with error addition off");

endmodule

`default_nettype wire

// ---- include/ppg_pkg.sv ----
/*
 * shared constants and helpers for the pseudo-random pattern generator:
 * register offsets, control field positions, reset values, tap table.
 * assumes a 32-bit register bus with word-aligned registers.
 */
`default_nettype none

package ppg_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_LFSR = 8'h08;
    localparam logic [7:0] OFS_MARK = 8'h0C;
    localparam logic [7:0] OFS_DPAT = 8'h10;
    localparam logic [7:0] OFS_DLEN = 8'h14;
    localparam logic [7:0] OFS_BEN  = 8'h18;
    localparam logic [7:0] OFS_BCYC = 8'h1C;
    localparam logic [7:0] OFS_MROW = 8'h20;
    localparam logic [7:0] OFS_MDAT = 8'h24;
    localparam logic [7:0] OFS_MCNT = 8'h28;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_LEN_LSB   = 0;
    localparam int CTL_POL       = 3;
    localparam int CTL_RATIO_LSB = 4;
    localparam int CTL_MODE      = 6;
    localparam int CTL_GANG_LSB  = 7;
    localparam int CTL_ERR       = 9;
    localparam int CTL_BURST     = 10;
    localparam int CTL_RUN       = 11;
    localparam int CTL_INIT      = 31;

    localparam logic [1:0] RATIO_HALF    = 2'h0;
    localparam logic [1:0] RATIO_QUARTER = 2'h1;
    localparam logic [1:0] RATIO_3Q      = 2'h2;

    // ------------------------------------------------------------
    // values after reset or initialisation, and the error addition gap
    // ------------------------------------------------------------
    localparam logic [2:0]  DEF_LEN_SEL = 3'h4;
    localparam logic [5:0]  DEF_DLEN    = 6'h02;
    localparam logic [15:0] DEF_MROW    = 16'h0600;
    localparam logic [15:0] DEF_MDAT    = 16'h0400;
    localparam logic [15:0] DEF_MCNT    = 16'h0101;
    localparam logic [31:0] DEF_MARK    = 32'h0000_0001;
    localparam logic [31:0] DEF_BEN     = 32'h0001_F400;
    localparam logic [31:0] DEF_BCYC    = 32'h00C3_5000;
    localparam logic [31:0] DEF_DPAT    = 32'h0000_0001;
    localparam logic [30:0] LFSR_SEED   = 31'h7FFF_FFFF;
    localparam logic [9:0]  ERR_GAP     = 10'h3E8;

    // ------------------------------------------------------------
    // length select to degree and second tap
    // ------------------------------------------------------------
    function automatic logic [4:0] ppg_len(input logic [2:0] sel);
        case (sel)
            3'h0: return 5'd7;
            3'h1: return 5'd9;
            3'h2: return 5'd10;
            3'h3: return 5'd11;
            3'h4: return 5'd15;
            3'h5: return 5'd20;
            3'h6: return 5'd23;
            default: return 5'd31;
        endcase
    endfunction

    function automatic logic [4:0] ppg_tap(input logic [2:0] sel);
        case (sel)
            3'h0: return 5'd6;
            3'h1: return 5'd5;
            3'h2: return 5'd7;
            3'h3: return 5'd9;
            3'h4: return 5'd14;
            3'h5: return 5'd3;
            3'h6: return 5'd18;
            default: return 5'd28;
        endcase
    endfunction

    function automatic logic [30:0] ppg_mask(input logic [2:0] sel);
        return 31'(({32'h0, 1'b1} << ppg_len(sel)) - 33'h1);
    endfunction

    // gang code 0 = one channel, 1 = two, 2 or 3 = four
    function automatic logic [31:0] ppg_scale(input logic [31:0] v, input logic [1:0] g);
        return (g == 2'h0) ? v : (g == 2'h1) ? {v[30:0], 1'b0} : {v[29:0], 2'b00};
    endfunction

endpackage

`default_nettype wire

// ---- rtl/ppg_lfsr.sv ----
/*
 * fibonacci shift register for all supported degrees, one stage per step.
 * assumes the caller holds len_sel stable except with reload.
 */
`default_nettype none

module ppg_lfsr
    import ppg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        clock_en,
    input  wire logic        step,
    input  wire logic        reload,
    input  wire logic [2:0]  len_sel,
    output logic      [30:0] state
);

    typedef struct packed {
        logic [30:0] sr;
    } ppg_lfsr_t;

    ppg_lfsr_t   s_reg;
    ppg_lfsr_t   s_next;
    logic        fb;
    logic [30:0] mask;

    always_comb begin
        mask   = ppg_mask(len_sel);
        fb     = s_reg.sr[ppg_tap(len_sel) - 5'd1] ^ s_reg.sr[ppg_len(len_sel) - 5'd1];
        s_next = s_reg;
        if (reload) begin
            // full seed: the length may change at this edge and must start at all ones
            s_next.sr = LFSR_SEED;
        end else if ((s_reg.sr & mask) == 31'h0) begin
            s_next.sr = LFSR_SEED & mask;
        end else if (step) begin
            s_next.sr = {s_reg.sr[29:0], fb} & mask;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.sr <= LFSR_SEED;
        end else if (clock_en) begin
            s_reg <= s_next;
        end
    end

    assign state = s_reg.sr;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_TAP_FEEDBACK: assert property (
        (clock_en && step && !reload && ((s_reg.sr & mask) != 31'h0)) |=> (s_reg.sr[0] == $past(fb))
    ) else $error("shift register input is not the tap exclusive-or");

    AST_ONE_STAGE: assert property (
        (clock_en && step && !reload && ((s_reg.sr & mask) != 31'h0))
        |=> ((s_reg.sr[30:1] & mask[30:1]) == ($past(s_reg.sr[29:0]) & mask[30:1]))
    ) else $error("shift register moved by other than one stage");

    AST_NONZERO: assert property (
        (clock_en && step && !reload) |=> ((s_reg.sr & ppg_mask(len_sel)) != 31'h0)
    ) else $error("shift register reached all zeros");

endmodule

`default_nettype wire

// ---- verification/ppg_rx_model.sv ----
/*
 * receiving end of the serial pattern: records bits, marker pulses and
 * gate cycles while capture is high.
 * assumes one bit per enabled clock and a bench that reads the record
 * between captures.
 */
`default_nettype none

module ppg_rx_model (
    input  wire logic clock,
    input  wire logic capture,
    input  wire logic data_out,
    input  wire logic marker_out,
    input  wire logic burst_gate
);
    timeunit 1ns;
    timeprecision 1ps;

    logic bits[$];
    int   markers;
    int   gates;

    // a closed capture wipes the record so each case starts clean
    always @(posedge clock) begin
        if (!capture) begin
            bits.delete();
            markers = 0;
            gates   = 0;
        end else begin
            bits.push_back(data_out);
            markers = markers + int'(marker_out === 1'b1);
            gates   = gates + int'(burst_gate === 1'b1);
        end
    end
endmodule

`default_nettype wire

// ---- verification/tb_prbs_pattern_generator.sv ----
/*
 * self-checking bench for the pattern generator: register defaults, gang
 * scaling, initialise, sequence period and runs, polarity, mark ratio,
 * data mode and burst gate.
 * assumes the package and design files are compiled first.
 */
`default_nettype none

module tb_prbs_pattern_generator
    import ppg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // shortened burst counts keep the run short
    localparam logic [31:0] EN_BITS  = 32'h0000_0008;
    localparam logic [31:0] CYC_BITS = 32'h0000_0014;

    logic        clock    = 1'b0;
    logic        reset_n  = 1'b0;
    logic        clock_en = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0000_0000;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic        capture  = 1'b0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        data_out;
    logic        marker_out;
    logic        burst_gate;
    logic [31:0] rd;
    int          num_errors   = 0;
    int          total_checks = 0;

    assign hready = hreadyout;

    always #12.5 clock = ~clock;

    ppg_top #(.BURST_EN_BITS(EN_BITS), .BURST_CYC_BITS(CYC_BITS)) u_dut (
        .clock(clock), .clock_en(clock_en), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .data_out(data_out), .marker_out(marker_out),
        .burst_gate(burst_gate)
    );

    ppg_rx_model u_rx (
        .clock(clock), .capture(capture), .data_out(data_out),
        .marker_out(marker_out), .burst_gate(burst_gate)
    );

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    // waits on hready with no own limit: the watchdog cuts a hang short
    task automatic bus_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] rdata);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(a, 1'b1, d, dummy);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] got;
        bus_xfer(a, 1'b0, 32'h0000_0000, got);
        check(nm, exp, got);
        check("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    // first bit of a sequence is a sequence one, so it also marks the run level
    task automatic run_case(input logic [31:0] ctrl, input int p, input int ones,
                            input logic first, input int nrun, input int gexp);
        logic q[$];
        int   o;
        int   rep;
        int   runs;
        int   k;
        o    = 0;
        rep  = 0;
        runs = 0;
        reg_wr(OFS_CTRL, ctrl);
        // first bit stands after the next edge, so capture must be open for it
        @(posedge clock);
        capture <= 1'b1;
        repeat (2 * p) @(posedge clock);
        capture <= 1'b0;
        @(negedge clock);
        q = u_rx.bits;
        check("gate cycles", gexp, u_rx.gates);
        if (ones >= 0) begin
            for (int i = 0; i < p; i++) begin
                o += int'(q[i] === 1'b1);
                rep += int'(q[i] !== q[i + p]);
                k = 0;
                while (k < nrun && q[i + k] === first) k++;
                if (nrun > 0 && k == nrun && q[i + p - 1] !== first && q[i + nrun] !== first)
                    runs++;
            end
            check("period mismatches", 32'h0000_0000, rep);
            check("high bits", ones, o);
            check("first bit", {31'h0, first}, {31'h0, q[0]});
            check("markers", 32'h0000_0002, u_rx.markers);
            if (nrun > 0) check("longest runs", 32'h0000_0001, runs);
        end
        $display("test ctrl %h done", ctrl);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        results();
    end

    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        reg_chk(OFS_CTRL, 32'h0000_0004, "ctrl");
        reg_chk(OFS_MARK, 32'h0000_0001, "mark");
        reg_chk(OFS_DLEN, 32'h0000_0002, "dlen");
        reg_chk(OFS_MROW, 32'h0000_0600, "mrow");
        reg_chk(OFS_MDAT, 32'h0000_0400, "mdat");
        reg_chk(OFS_MCNT, 32'h0000_0101, "mcnt");
        reg_chk(OFS_BEN, EN_BITS, "ben");
        reg_chk(OFS_BCYC, CYC_BITS, "bcyc");
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_chk(8'h40, 32'h0000_0000, "unmapped");
        $display("test defaults done");
        for (int g = 1; g < 3; g++) begin
            reg_wr(OFS_CTRL, 32'(g) << 7);
            reg_chk(OFS_DLEN, 32'h0000_0002 << g, "dlen scaled");
            reg_chk(OFS_MROW, 32'h0000_0600 << g, "mrow scaled");
            reg_chk(OFS_MDAT, 32'h0000_0400 << g, "mdat scaled");
            reg_chk(OFS_BEN, EN_BITS << g, "ben scaled");
            reg_chk(OFS_BCYC, CYC_BITS << g, "bcyc scaled");
        end
        reg_wr(OFS_MARK, 32'h0000_0005);
        reg_wr(OFS_CTRL, 32'h8000_03AB);
        reg_chk(OFS_CTRL, 32'h0000_0004, "ctrl after init");
        reg_chk(OFS_DLEN, 32'h0000_0002, "dlen after init");
        reg_chk(OFS_MARK, 32'h0000_0001, "mark after init");
        $display("test gang and init done");
        run_case(32'h0000_0800, 127, 63, 1'b0, 7, 254);
        run_case(32'h0000_0801, 511, 255, 1'b0, 9, 1022);
        run_case(32'h0000_080A, 1023, 512, 1'b1, 10, 2046);
        run_case(32'h0000_080B, 2047, 1024, 1'b1, 11, 4094);
        run_case(32'h0000_0804, 32767, 16383, 1'b0, 15, 65534);
        run_case(32'h0000_0818, 127, 32, 1'b1, 0, 254);
        run_case(32'h0000_0828, 127, 96, 1'b1, 0, 254);
        run_case(32'h0000_0848, 2, 1, 1'b1, 0, 4);
        run_case(32'h0000_0C00, 20, -1, 1'b0, 0, 16);
        // error addition on: the first bit after restart is flipped, the next is not
        reg_wr(OFS_CTRL, 32'h0000_0A08);
        repeat (2) @(posedge clock);
        check("added error", 32'h0000_0000, {31'h0, data_out});
        @(posedge clock);
        check("bit after error", 32'h0000_0001, {31'h0, data_out});
        reg_chk(OFS_STAT, 32'h0000_0003, "position");
        clock_en <= 1'b0;
        repeat (4) @(posedge clock);
        clock_en <= 1'b1;
        reg_chk(OFS_STAT, 32'h0000_0005, "frozen position");
        $display("test error addition and freeze done");
        bus_xfer(OFS_LFSR, 1'b0, 32'h0000_0000, rd);
        check("lfsr nonzero", 32'h0000_0001, {31'h0, rd !== 32'h0000_0000});
        $display("test patterns done");
        results();
    end
endmodule

`default_nettype wire
